// ### hw/complementary_generator.v
// Complementary PWM output generator with AXI4-Lite register slave
`timescale 1ns/100ps
`include "cog_regs.vh"
module complementary_generator (
    input  wire        clk,
    input  wire        rst,
    input  wire        ce,
    input  wire        awvalid,
    output reg         awready,
    input  wire [7:0]  awaddr,
    input  wire        wvalid,
    output reg         wready,
    input  wire [31:0] wdata,
    input  wire [3:0]  wstrb,
    output reg         bvalid,
    input  wire        bready,
    output reg  [1:0]  bresp,
    input  wire        arvalid,
    output reg         arready,
    input  wire [7:0]  araddr,
    output reg         rvalid,
    input  wire        rready,
    output reg  [31:0] rdata,
    output reg  [1:0]  rresp,
    input  wire        pwm_unit_three_output,
    input  wire        capture_compare_two_output,
    input  wire        capture_compare_one_output,
    input  wire [3:0]  comparator_synced,
    input  wire        generator_input_pin,
    input  wire        timer_four_output,
    input  wire        timer_two_output,
    input  wire        logic_cell_two_output,
    input  wire [3:0]  timing_clock_taps,
    output reg  [3:0]  generatorOut,
    output reg  [3:0]  generatorOutEnN
);
    // Register state
    reg  [31:0] generator_control_0;
    reg  [7:0]  rising_event_source_enable_0;
    reg  [7:0]  fallSrc;
    reg  [7:0]  shutdown_source_enable_1;
    reg  [15:0] phaseTime;
    reg  [15:0] deadTime;
    reg  [15:0] blankTime;
    reg  [15:0] outCfg;
    reg  [7:0]  senseCfg;
    reg  [1:0]  clkSel;
    reg  [7:0]  wAddr;
    reg  [31:0] wData;
    reg         haveAw;
    reg         haveW;
    reg         shutdown;
    reg         active;
    reg         steerPhase;
    reg  [7:0]  delayLine;
    reg         prevRise;
    reg         prevFall;
    reg  [2:0]  tickDiv;

    wire [2:0] mode      = generator_control_0[2:0];
    wire       genEn     = generator_control_0[`CTL_EN_BIT];
    wire       autoRst   = generator_control_0[`CTL_ARSEN_BIT];
    wire       dbAsync   = generator_control_0[`CTL_DBASYNC_BIT];
    wire [3:0] steerMask = generator_control_0[11:8];

    // Source vector shared by rise and fall selection
    wire [7:0] eventSrc = {pwm_unit_three_output,
                           capture_compare_two_output,
                           capture_compare_one_output,
                           comparator_synced, generator_input_pin};

    // Any enabled source asserts the event
    wire riseLvl = |(eventSrc & rising_event_source_enable_0);
    wire fallLvl = |(eventSrc & fallSrc);
    // Level-high or edge per direction; sense bit 0 rise, bit 1 fall
    wire riseEdgeMode = senseCfg[0];
    wire fallEdgeMode = senseCfg[1];
    wire riseEvt = riseEdgeMode ? (riseLvl & ~prevRise) : riseLvl;
    wire fallEvt = fallEdgeMode ? (fallLvl & ~prevFall) : fallLvl;

    // Shutdown sources: timers active high, others active low
    wire [7:0] shutSrc = {timer_four_output, timer_two_output,
                          ~logic_cell_two_output, ~comparator_synced,
                          ~generator_input_pin};
    wire shutReq = |(shutSrc & shutdown_source_enable_1);

    // Timing clock pick: system clock, internal divider or one of two tap enables
    // Divided clock is a one-cycle strobe, so timers count once per 8
    wire tick = (clkSel == 2'h0) ? 1'b1 :
                (clkSel == 2'h1) ? (tickDiv == 3'h7) :
                (clkSel == 2'h2) ? timing_clock_taps[0] :
                timing_clock_taps[1];

    // Timers: phase rise/fall, dead rise/fall, blank rise/fall
    wire phRBusy, phRDone, phFBusy, phFDone;
    // Dead-band and blanking timers only report busy
    wire dbRBusy, dbFBusy;
    wire blRBusy, blFBusy;
    wire acceptRise = riseEvt & ~active & ~blFBusy & ~phRBusy;
    wire acceptFall = fallEvt & active & ~blRBusy & ~phFBusy;
    wire goHigh = phRDone & ~shutdown;
    wire goLow  = phFDone;

    event_timer uPhR (.clk(clk), .rst(rst), .ce(ce), .tick(tick),
        .start(acceptRise), .load(phaseTime[7:0]),
        .busy(phRBusy), .done(phRDone));
    event_timer uPhF (.clk(clk), .rst(rst), .ce(ce), .tick(tick),
        .start(acceptFall), .load(phaseTime[15:8]),
        .busy(phFBusy), .done(phFDone));
    event_timer uDbR (.clk(clk), .rst(rst), .ce(ce), .tick(tick),
        .start(goHigh), .load(deadTime[7:0]),
        .busy(dbRBusy), .done());
    event_timer uDbF (.clk(clk), .rst(rst), .ce(ce), .tick(tick),
        .start(goLow), .load(deadTime[15:8]),
        .busy(dbFBusy), .done());
    event_timer uBlR (.clk(clk), .rst(rst), .ce(ce), .tick(tick),
        .start(goHigh), .load(blankTime[7:0]),
        .busy(blRBusy), .done());
    event_timer uBlF (.clk(clk), .rst(rst), .ce(ce), .tick(tick),
        .start(goLow), .load(blankTime[15:8]),
        .busy(blFBusy), .done());

    // Delay chain taps replace clocked dead band; tap picks length
    wire chainR = delayLine[deadTime[2:0]] & active;
    wire chainF = ~(delayLine[deadTime[10:8]] | active);
    wire primary   = dbAsync ? chainR : (active & ~dbRBusy);
    wire secondary = dbAsync ? chainF : (~active & ~dbFBusy);

    // Per-mode raw drive of the four outputs
    reg [3:0] next_raw;
    always @* begin
        case (mode)
            `MODE_STEER:  next_raw = {4{active}} & steerMask;
            `MODE_SSTEER: next_raw = {4{active}} & outCfg[15:12];
            `MODE_FWD:    next_raw = {1'b0, active, 1'b0, 1'b1};
            `MODE_REV:    next_raw = {active, 1'b0, 1'b1, 1'b0};
            `MODE_HALF:   next_raw = {secondary, primary,
                                      secondary, primary};
            `MODE_PUSH:   next_raw = {~steerPhase & primary,
                                      steerPhase & primary,
                                      ~steerPhase & primary,
                                      steerPhase & primary};
            default:      next_raw = 4'h0;
        endcase
    end

    // Output stage: polarity, shutdown override per output
    // Disabled generator parks each output at its polarity level
    reg [3:0] next_out;
    reg [3:0] next_enN;
    integer   i;
    always @* begin
        next_out = 4'h0;
        next_enN = 4'hF;
        for (i = 0; i < 4; i = i + 1) begin
            if (!genEn) begin
                next_out[i] = outCfg[8 + i];
                next_enN[i] = 1'b0;
            end else if (shutdown) begin
                case (outCfg[2*i +: 2])
                    `OVR_LOW:  next_out[i] = 1'b0;
                    `OVR_HIGH: next_out[i] = 1'b1;
                    `OVR_OFF:  next_out[i] = outCfg[8 + i];
                    default:   next_out[i] = 1'b0;
                endcase
                next_enN[i] = (outCfg[2*i +: 2] == `OVR_HIZ);
            end else begin
                next_out[i] = next_raw[i] ^ outCfg[8 + i];
                next_enN[i] = 1'b0;
            end
        end
    end

    // Write strobes, ahead of the cycle state that reads them;
    // a restart write clears shutdown at the edge the word lands
    wire wriCtl = haveAw && haveW && !bvalid
                  && (wAddr == `ADDR_CONTROL0);
    wire doWrite = haveAw && haveW && !bvalid;

    // Cycle state: rise sets active, fall clears it
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            active     <= 1'b0;
            steerPhase <= 1'b0;
            shutdown   <= 1'b0;
            prevRise   <= 1'b0;
            prevFall   <= 1'b0;
            delayLine  <= 8'h00;
            tickDiv    <= 3'h0;
            generatorOut    <= 4'h0;
            generatorOutEnN <= 4'hF;
        end else if (ce) begin
            prevRise  <= riseLvl;
            prevFall  <= fallLvl;
            tickDiv   <= tickDiv + 3'h1;
            delayLine <= {delayLine[6:0], active};
            generatorOut    <= next_out;
            generatorOutEnN <= next_enN;
            if (!genEn) begin
                active <= 1'b0;
            end else if (goHigh) begin
                active     <= 1'b1;
                steerPhase <= ~steerPhase;
            end else if (goLow || shutdown) begin
                active <= 1'b0;
            end
            // Shutdown is sticky unless auto-restart; restart needs rise
            // A request in the same cycle outweighs either clear
            if (shutReq) begin
                shutdown <= 1'b1;
            end else if (autoRst && riseEvt) begin
                shutdown <= 1'b0;
            end else if (wriCtl && wData[`CTL_RSTART_BIT]) begin
                shutdown <= 1'b0;
            end
        end
    end

    // AXI4-Lite write path: address and data in any order
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            awready <= 1'b1;
            wready  <= 1'b1;
            haveAw  <= 1'b0;
            haveW   <= 1'b0;
            wAddr   <= 8'h00;
            wData   <= 32'h00000000;
            bvalid  <= 1'b0;
            bresp   <= `RESP_OKAY;
            generator_control_0          <= `CTL_RESET;
            rising_event_source_enable_0 <= `SRC_RESET;
            fallSrc                      <= `SRC_RESET;
            shutdown_source_enable_1     <= `SRC_RESET;
            phaseTime <= `TIME_RESET;
            deadTime  <= `TIME_RESET;
            blankTime <= `TIME_RESET;
            outCfg    <= `OUTCFG_RESET;
            senseCfg  <= 8'h00;
            clkSel    <= 2'h0;
        end else if (ce) begin
            if (awvalid && awready) begin
                wAddr   <= awaddr;
                haveAw  <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wData  <= wdata;
                haveW  <= 1'b1;
                wready <= 1'b0;
            end
            if (doWrite) begin
                bvalid <= 1'b1;
                bresp  <= `RESP_OKAY;
                case (wAddr)
                    `ADDR_CONTROL0: generator_control_0 <= wData;
                    `ADDR_RISE_SRC: rising_event_source_enable_0
                                        <= wData[7:0];
                    `ADDR_FALL_SRC: fallSrc <= wData[7:0];
                    `ADDR_SHUT_SRC: shutdown_source_enable_1
                                        <= wData[7:0];
                    `ADDR_PHASE:    phaseTime <= wData[15:0];
                    `ADDR_DEADBAND: deadTime  <= wData[15:0];
                    `ADDR_BLANK:    blankTime <= wData[15:0];
                    `ADDR_OUTCFG: begin
                        outCfg   <= wData[15:0];
                        senseCfg <= wData[23:16];
                        clkSel   <= wData[25:24];
                    end
                    default:        bresp <= `RESP_SLVERR;
                endcase
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                haveAw  <= 1'b0;
                haveW   <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // AXI4-Lite read path: one-cycle answer after address taken
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= `RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rresp   <= `RESP_OKAY;
                case (araddr)
                    `ADDR_CONTROL0: rdata <= generator_control_0;
                    `ADDR_RISE_SRC: rdata <= {24'h000000,
                                        rising_event_source_enable_0};
                    `ADDR_FALL_SRC: rdata <= {24'h000000, fallSrc};
                    `ADDR_SHUT_SRC: rdata <= {24'h000000,
                                        shutdown_source_enable_1};
                    `ADDR_PHASE:    rdata <= {16'h0000, phaseTime};
                    `ADDR_DEADBAND: rdata <= {16'h0000, deadTime};
                    `ADDR_BLANK:    rdata <= {16'h0000, blankTime};
                    `ADDR_OUTCFG:   rdata <= {6'h00, clkSel, senseCfg,
                                              outCfg};
                    `ADDR_STATUS:   rdata <= {24'h000000, generatorOut,
                                              2'h0, shutdown, active};
                    default: begin
                        rdata <= 32'h00000000;
                        rresp <= `RESP_SLVERR;
                    end
                endcase
            end else if (rvalid && rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end
endmodule // complementary_generator

// ### hw/cog_regs.vh
// Register map, field positions, reset values and response, mode and override codes
`ifndef GENERATOR_REGS_VH
`define GENERATOR_REGS_VH
`define ADDR_CONTROL0    8'h00
`define ADDR_RISE_SRC    8'h04
`define ADDR_FALL_SRC    8'h08
`define ADDR_SHUT_SRC    8'h0C
`define ADDR_PHASE       8'h10
`define ADDR_DEADBAND    8'h14
`define ADDR_BLANK       8'h18
`define ADDR_OUTCFG      8'h1C
`define ADDR_STATUS      8'h20
`define CTL_EN_BIT       7
`define CTL_ARSEN_BIT    6
`define CTL_RSTART_BIT   5
`define CTL_DBASYNC_BIT  4
`define CTL_MODE_LSB     0
`define CTL_RESET        32'h00000000
`define SRC_RESET        8'h00
`define TIME_RESET       16'h0000
`define OUTCFG_RESET     16'h0000
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`define MODE_STEER       3'h0
`define MODE_SSTEER      3'h1
`define MODE_FWD         3'h2
`define MODE_REV         3'h3
`define MODE_HALF        3'h4
`define MODE_PUSH        3'h5
`define OVR_LOW          2'h0
`define OVR_HIGH         2'h1
`define OVR_OFF          2'h2
`define OVR_HIZ          2'h3
`endif

// ### hw/event_timer.v
// Down-counting interval timer gated by the generator timing clock enable
`timescale 1ns/100ps
module event_timer (
    input  wire       clk,
    input  wire       rst,
    input  wire       ce,
    input  wire       tick,
    input  wire       start,
    input  wire [7:0] load,
    output reg        busy,
    output reg        done
);
    reg [7:0] count;

    // Start reloads; zero load finishes on next tick
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= 8'h00;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            if (start) begin
                count <= load;
                busy  <= 1'b1;
            end else if (busy && tick) begin
                if (count == 8'h00) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count - 8'h01;
                end
            end
        end
    end
endmodule // event_timer

// ### bench/cog_monitor.sv
// Checker for the register bus of the complementary generator
`timescale 1ns/100ps
`include "cog_regs.vh"
module generator_bus_monitor (
    input wire        clk,
    input wire        rst,
    input wire        awvalid,
    input wire        awready,
    input wire [7:0]  awaddr,
    input wire        wvalid,
    input wire        wready,
    input wire        bvalid,
    input wire        bready,
    input wire [1:0]  bresp,
    input wire        arvalid,
    input wire        arready,
    input wire [7:0]  araddr,
    input wire        rvalid,
    input wire        rready,
    input wire [31:0] rdata,
    input wire [1:0]  rresp
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Taken requests, split by whether the word is mapped
    sequence s_wr;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_rd;
        arvalid && arready;
    endsequence
    sequence s_rd_bad;
        s_rd ##0 (araddr[7:2] > 6'h08);
    endsequence
    sequence s_wr_bad;
        s_wr ##0 (awaddr[7:2] > 6'h08);
    endsequence
    // Write lands one edge after both parts are held, answered at that same edge
    AST_B_NEXT: assert property (s_wr |-> ##2 bvalid)
        else $error("write answer late");
    AST_R_NEXT: assert property (s_rd |=> rvalid)
        else $error("read answer late");
    AST_B_HOLD: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped");
    AST_R_HOLD: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer changed");
    AST_B_DROP: assert property (bvalid && bready |=> !bvalid)
        else $error("write answer repeated");
    AST_R_BUSY: assert property (rvalid |-> !arready)
        else $error("read taken while pending");
    AST_W_BUSY: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while pending");
    AST_BAD_RD: assert property (
        s_rd_bad |=> rresp == `RESP_SLVERR && rdata == 32'h0)
        else $error("unmapped read answered");
    AST_BAD_WR: assert property (
        s_wr_bad |-> ##2 bresp == `RESP_SLVERR)
        else $error("unmapped write answered");
    AST_REL: assert property (
        $fell(rst) |-> awready && arready && !bvalid && !rvalid)
        else $error("bus not idle after reset");
endmodule // generator_bus_monitor

// ### bench/event_source_model.sv
// Behavioural model of the event, timer and pin sources
`timescale 1ns/100ps
module event_source_model (
    input  wire       clk,
    input  wire       rst,
    input  wire [7:0] srcLevel,
    input  wire [1:0] timerLevel,
    input  wire       cellLevel,
    output reg        pwmThree,
    output reg        capTwo,
    output reg        capOne,
    output reg  [3:0] compSynced,
    output reg        inputPin,
    output reg        timerFour,
    output reg        timerTwo,
    output reg        cellTwo,
    output reg  [3:0] taps
);
    reg [2:0] div;
    // Sources move only at edges, as on-chip peripherals do
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            {pwmThree, capTwo, capOne, compSynced, inputPin} <= 8'h1F;
            {timerFour, timerTwo, cellTwo} <= 3'h1;
            div <= 3'h0;
            taps <= 4'h0;
        end else begin
            {pwmThree, capTwo, capOne, compSynced, inputPin} <= srcLevel;
            {timerFour, timerTwo} <= timerLevel;
            cellTwo <= cellLevel;
            div <= div + 3'h1;
            // Tap 0 every 4 cycles, tap 1 every 8
            taps <= {2'h0, div == 3'h7, div[1:0] == 2'h3};
        end
    end
endmodule // event_source_model

// ### bench/complementary_generator_tb_top.sv
// Self-checking bench for the complementary generator
`timescale 1ns/100ps
`include "cog_regs.vh"
module complementary_generator_tb_top;
    reg         clk, rst, awvalid, wvalid, bready, arvalid, rready;
    reg  [7:0]  awaddr, araddr, srcLevel;
    reg  [31:0] wdata, rv;
    reg  [1:0]  timerLevel, resp;
    reg         cellLevel;
    wire        awready, wready, bvalid, arready, rvalid;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire        pwmThree, capTwo, capOne, inputPin, timerFour, timerTwo;
    wire        cellTwo;
    wire [3:0]  compSynced, taps, generatorOut, generatorOutEnN;
    integer     n_fail, tests_run, i;

    complementary_generator dut (
        .clk(clk), .rst(rst), .ce(1'h1),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .pwm_unit_three_output(pwmThree),
        .capture_compare_two_output(capTwo),
        .capture_compare_one_output(capOne),
        .comparator_synced(compSynced), .generator_input_pin(inputPin),
        .timer_four_output(timerFour), .timer_two_output(timerTwo),
        .logic_cell_two_output(cellTwo), .timing_clock_taps(taps),
        .generatorOut(generatorOut), .generatorOutEnN(generatorOutEnN)
    );
    event_source_model partner (
        .clk(clk), .rst(rst), .srcLevel(srcLevel),
        .timerLevel(timerLevel), .cellLevel(cellLevel),
        .pwmThree(pwmThree), .capTwo(capTwo), .capOne(capOne),
        .compSynced(compSynced), .inputPin(inputPin),
        .timerFour(timerFour), .timerTwo(timerTwo), .cellTwo(cellTwo),
        .taps(taps)
    );

    // 20 MHz clock
    initial clk = 1'h0;
    always #25 clk = ~clk;

    task end_sim;
        begin
            $display("checks %0d mismatches %0d", tests_run, n_fail);
            if (n_fail == 0 && tests_run > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("mismatch at %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    // Write: address and data offered together, each dropped when taken
    task wr(input [7:0] a, input [31:0] d);
        reg     p, q, b;
        integer n;
        begin
            @(posedge clk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'h1;
            wvalid <= 1'h1;
            bready <= 1'h1;
            p = 1;
            q = 1;
            b = 1;
            n = 0;
            while (b && n < 100) begin
                @(posedge clk);
                n = n + 1;
                if (p && awready) begin p = 0; awvalid <= 1'h0; end
                if (q && wready) begin q = 0; wvalid <= 1'h0; end
                if (!p && !q && bvalid) begin
                    b = 0;
                    resp = bresp;
                    bready <= 1'h0;
                end
            end
            if (b) begin n_fail = n_fail + 1; end_sim; end
        end
    endtask

    task rd(input [7:0] a, output [31:0] v);
        reg     p, q;
        integer n;
        begin
            @(posedge clk);
            araddr <= a;
            arvalid <= 1'h1;
            rready <= 1'h1;
            p = 1;
            q = 1;
            n = 0;
            while (q && n < 100) begin
                @(posedge clk);
                n = n + 1;
                if (p && arready) begin p = 0; arvalid <= 1'h0; end
                else if (!p && rvalid) begin
                    q = 0;
                    v = rdata;
                    resp = rresp;
                    rready <= 1'h0;
                end
            end
            if (q) begin n_fail = n_fail + 1; end_sim; end
        end
    endtask

    // Short pulse on event sources; wait covers phase delay on tap 0
    task pulse(input [7:0] m);
        begin
            @(posedge clk);
            srcLevel <= 8'h1F | m;
            repeat (2) @(posedge clk);
            srcLevel <= 8'h1F;
            repeat (60) @(posedge clk);
            rd(`ADDR_STATUS, rv);
        end
    endtask

    // Make shutdown source k active or idle
    task act(input integer k, input on);
        begin
            @(posedge clk);
            if (k == 7) timerLevel[1] <= on;
            else if (k == 6) timerLevel[0] <= on;
            else if (k == 5) cellLevel <= ~on;
            else srcLevel[k] <= ~on;
        end
    endtask

    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata, timerLevel} = 50'h0;
        srcLevel = 8'h1F;
        cellLevel = 1'h1;
        n_fail = 0;
        tests_run = 0;
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        rd(`ADDR_RISE_SRC, rv); chk(rv, 32'h0);
        rd(`ADDR_SHUT_SRC, rv); chk(rv, 32'h0);
        rd(8'h40, rv); chk({resp, rv[29:0]}, 32'h80000000);
        wr(8'h40, 32'h5A); chk({30'h0, resp}, 32'h2);
        wr(`ADDR_RISE_SRC, 32'h1A5);
        rd(`ADDR_RISE_SRC, rv); chk(rv, 32'hA5);
        wr(`ADDR_FALL_SRC, 32'h5A);
        rd(`ADDR_FALL_SRC, rv); chk(rv, 32'h5A);
        // Idle generator shows the polarity bits
        wr(`ADDR_OUTCFG, 32'hA00);
        repeat (4) @(posedge clk);
        chk({28'h0, generatorOut}, 32'hA);
        chk({28'h0, generatorOutEnN}, 32'h0);
        // Edge events, tap 0 timing clock, phase delay
        wr(`ADDR_RISE_SRC, 32'h80);
        wr(`ADDR_FALL_SRC, 32'h40);
        wr(`ADDR_PHASE, 32'h102);
        wr(`ADDR_OUTCFG, 32'h2030000);
        wr(`ADDR_CONTROL0, 32'h80);
        pulse(8'h80); chk(rv & 32'h1, 32'h1);
        pulse(8'h20); chk(rv & 32'h1, 32'h1);
        pulse(8'h40); chk(rv & 32'h1, 32'h0);
        // Each mode with the cycle inactive: D..A nibble per mode
        for (i = 0; i < 6; i = i + 1) begin
            wr(`ADDR_CONTROL0, 32'h80 | i);
            rd(`ADDR_CONTROL0, rv); chk(rv & 32'h7, i);
            chk({28'h0, generatorOut}, 32'hF & (32'hA2100 >> 4 * i));
        end
        // Each shutdown source alone, masked, then among all
        wr(`ADDR_RISE_SRC, 32'h0);
        wr(`ADDR_OUTCFG, 32'hE1);
        for (i = 0; i < 8; i = i + 1) begin
            wr(`ADDR_SHUT_SRC, ~(32'h1 << i) & 32'hFF);
            act(i, 1'h1);
            rd(`ADDR_STATUS, rv); chk(rv & 32'h2, 32'h0);
            wr(`ADDR_SHUT_SRC, 32'hFF);
            rd(`ADDR_STATUS, rv); chk(rv & 32'h2, 32'h2);
            chk({29'h0, generatorOut[2:0]}, 32'h1);
            chk({28'h0, generatorOutEnN}, 32'h8);
            act(i, 1'h0);
            rd(`ADDR_STATUS, rv); chk(rv & 32'h2, 32'h2);
            wr(`ADDR_CONTROL0, 32'hA0);
            rd(`ADDR_STATUS, rv); chk(rv & 32'h2, 32'h0);
        end
        // Reset in mid-run clears source enables and cycle state
        rst <= 1'h1;
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        rd(`ADDR_SHUT_SRC, rv); chk(rv, 32'h0);
        rd(`ADDR_STATUS, rv); chk(rv, 32'h0);
        end_sim;
    end

    // Hang guard, far beyond the several hundred cycles needed
    initial begin
        #500000;
        n_fail = n_fail + 1;
        end_sim;
    end
endmodule // complementary_generator_tb_top

bind complementary_generator generator_bus_monitor mon (
    .clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp)
);
